// ===== core/tpsp_pkg.sv
package tpsp_pkg;

  // ---------------------------------------------------------------
  // Test access port controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TPSP_TLR = 4'h0,
    TPSP_RTI = 4'h1,
    TPSP_SEL_DR = 4'h3,
    TPSP_CAP_DR = 4'h2,
    TPSP_SH_DR = 4'h6,
    TPSP_EX1_DR = 4'h7,
    TPSP_PAU_DR = 4'h5,
    TPSP_EX2_DR = 4'h4,
    TPSP_UPD_DR = 4'hC,
    TPSP_SEL_IR = 4'hD,
    TPSP_CAP_IR = 4'hF,
    TPSP_SH_IR = 4'hE,
    TPSP_EX1_IR = 4'hA,
    TPSP_PAU_IR = 4'hB,
    TPSP_EX2_IR = 4'h9,
    TPSP_UPD_IR = 4'h8
  } tpsp_state_t;

  // ---------------------------------------------------------------
  // Instruction register and constants
  // ---------------------------------------------------------------
  localparam int TPSP_IR_W = 4;
  localparam logic [3:0] TPSP_IR_RESET = 4'h1;
  localparam logic [3:0] TPSP_IR_BYPASS = 4'hF;
  localparam logic [3:0] TPSP_IR_PROBE = 4'h2;
  localparam logic [3:0] TPSP_IR_LOCK = 4'h3;
  localparam int TPSP_SEL_W = 8;
  localparam logic [7:0] TPSP_SEL_RESET = 8'h00;
  localparam int TPSP_NODES = 256;
  localparam int TPSP_TMS_HIGH_CLKS = 5;

endpackage : tpsp_pkg

// ===== core/tpsp_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tpsp_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic [3:0] state;
  modport ctrl (output tck_rise, output tck_fall, output tms, input state);
  modport fsm (input tck_rise, input tck_fall, input tms, output state);
endinterface : tpsp_if
`default_nettype wire

// ===== core/tpsp_fsm.sv
`timescale 1ns/10ps
`default_nettype none
module tpsp_fsm
  import tpsp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  tpsp_if.fsm link
);

  tpsp_state_t state_reg;
  tpsp_state_t state_next;

  // ---------------------------------------------------------------
  // Standard transitions; five high mode-select clocks reach reset
  // ---------------------------------------------------------------
  always_comb begin
    unique case (state_reg)
      TPSP_TLR: state_next = link.tms ? TPSP_TLR : TPSP_RTI;
      TPSP_RTI: state_next = link.tms ? TPSP_SEL_DR : TPSP_RTI;
      TPSP_SEL_DR: state_next = link.tms ? TPSP_SEL_IR : TPSP_CAP_DR;
      TPSP_CAP_DR: state_next = link.tms ? TPSP_EX1_DR : TPSP_SH_DR;
      TPSP_SH_DR: state_next = link.tms ? TPSP_EX1_DR : TPSP_SH_DR;
      TPSP_EX1_DR: state_next = link.tms ? TPSP_UPD_DR : TPSP_PAU_DR;
      TPSP_PAU_DR: state_next = link.tms ? TPSP_EX2_DR : TPSP_PAU_DR;
      TPSP_EX2_DR: state_next = link.tms ? TPSP_UPD_DR : TPSP_SH_DR;
      TPSP_UPD_DR: state_next = link.tms ? TPSP_SEL_DR : TPSP_RTI;
      TPSP_SEL_IR: state_next = link.tms ? TPSP_TLR : TPSP_CAP_IR;
      TPSP_CAP_IR: state_next = link.tms ? TPSP_EX1_IR : TPSP_SH_IR;
      TPSP_SH_IR: state_next = link.tms ? TPSP_EX1_IR : TPSP_SH_IR;
      TPSP_EX1_IR: state_next = link.tms ? TPSP_UPD_IR : TPSP_PAU_IR;
      TPSP_PAU_IR: state_next = link.tms ? TPSP_EX2_IR : TPSP_PAU_IR;
      TPSP_EX2_IR: state_next = link.tms ? TPSP_UPD_IR : TPSP_SH_IR;
      TPSP_UPD_IR: state_next = link.tms ? TPSP_SEL_DR : TPSP_RTI;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= TPSP_TLR;
    end else if (ce && link.tck_rise) begin
      state_reg <= state_next;
    end
  end

  assign link.state = state_reg;

endmodule : tpsp_fsm
`default_nettype wire

// ===== core/tpsp_top.sv
// Functional notes
// - In flexible mode, mode-select low turns clock and data pins into scan pins.
// - Pins stay in test mode until the controller reaches test-logic-reset.
// - Reaching test-logic-reset hands clock and data pins back as user I/O.
// - Five clocks with mode-select high reach test-logic-reset.
// - Dedicated mode follows the standard controller with no pin sharing.
// - Test clock times probing; data in feeds scan and probe select; data out shifts.
// - A selected internal node drives probe A; probe B gives a second node.
// - Each probe pin works as ordinary user I/O when probing is off.
// - A permanent one-way lock removes all probe observation.
`timescale 1ns/10ps
`default_nettype none
module tpsp_top
  import tpsp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic dedicated_mode,
  input wire logic tms_pin,
  input wire logic tck_pin_in,
  output logic tck_pin_out,
  output logic tck_pin_oe,
  input wire logic tdi_pin_in,
  output logic tdi_pin_out,
  output logic tdi_pin_oe,
  input wire logic tdo_pin_in,
  output logic tdo_pin_out,
  output logic tdo_pin_oe,
  output logic probe_a_pin_out,
  output logic probe_a_pin_oe,
  output logic probe_b_pin_out,
  output logic probe_b_pin_oe,
  input wire logic [255:0] nodes,
  input wire logic [2:0] user_out,
  input wire logic [2:0] user_oe,
  output logic [2:0] user_in,
  input wire logic user_pa_out,
  input wire logic user_pa_oe,
  input wire logic user_pb_out,
  input wire logic user_pb_oe,
  output logic test_mode,
  output logic probe_locked
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic tck_d_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      // The clock bit resets to its idle low level so no false edge follows reset.
      s1_reg <= 6'h2F;
      s2_reg <= 6'h2F;
      tck_d_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= {tms_pin, tck_pin_in, tdi_pin_in, tdo_pin_in, 2'b00};
      s2_reg <= s1_reg;
      tck_d_reg <= s2_reg[4];
    end
  end

  logic tms_s;
  logic tck_s;
  logic tdi_s;
  assign tms_s = s2_reg[5];
  assign tck_s = s2_reg[4];
  assign tdi_s = s2_reg[3];

  tpsp_if link ();
  assign link.tms = tms_s;
  assign link.tck_rise = tck_s & ~tck_d_reg;
  assign link.tck_fall = ~tck_s & tck_d_reg;

  tpsp_fsm u_fsm (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .link(link)
  );

  tpsp_state_t st;
  assign st = tpsp_state_t'(link.state);

  // ---------------------------------------------------------------
  // Pin sharing mode
  // ---------------------------------------------------------------
  logic test_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      test_reg <= 1'b0;
    end else if (ce) begin
      if (dedicated_mode) begin
        test_reg <= 1'b1;
      end else if (!tms_s) begin
        test_reg <= 1'b1;
      end else if (st == TPSP_TLR) begin
        test_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Instruction, shift and probe select registers
  // ---------------------------------------------------------------
  logic [3:0] ir_sh_reg;
  logic [3:0] ir_reg;
  logic [7:0] sel_sh_reg;
  logic [7:0] sel_a_reg;
  logic [7:0] sel_b_reg;
  logic byp_reg;
  logic lock_reg;
  logic tdo_reg;
  logic tdo_en_reg;
  logic tck_ok;
  // Rising test clock edges reach these registers only while the pins serve the tester; the controller steps on every edge.
  assign tck_ok = ce & test_reg & link.tck_rise;

  always_ff @(posedge clk) begin
    if (srst) begin
      ir_sh_reg <= TPSP_IR_RESET;
      ir_reg <= TPSP_IR_RESET;
      sel_sh_reg <= TPSP_SEL_RESET;
      byp_reg <= 1'b0;
    end else if (tck_ok) begin
      unique case (st)
        TPSP_TLR: ir_reg <= TPSP_IR_RESET;
        TPSP_CAP_IR: ir_sh_reg <= TPSP_IR_RESET;
        TPSP_SH_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]};
        TPSP_UPD_IR: ir_reg <= ir_sh_reg;
        TPSP_CAP_DR: byp_reg <= 1'b0;
        TPSP_SH_DR: begin
          byp_reg <= tdi_s;
          sel_sh_reg <= {tdi_s, sel_sh_reg[7:1]};
        end
        default: begin
        end
      endcase
    end
  end

  // The lock has no clear path except the first reset after power-up; later resets leave it set.
  always_ff @(posedge clk) begin
    if (srst) begin
      sel_a_reg <= TPSP_SEL_RESET;
      sel_b_reg <= TPSP_SEL_RESET;
    end else if (tck_ok && st == TPSP_UPD_DR && ir_reg == TPSP_IR_PROBE && !lock_reg) begin
      sel_b_reg <= sel_a_reg;
      sel_a_reg <= sel_sh_reg;
    end
  end

  // Power-up value; only the first reset after power-up may clear the lock.
  logic lock_init_reg = 1'b0;
  always_ff @(posedge clk) begin
    if (srst && !lock_init_reg) begin
      lock_reg <= 1'b0;
      lock_init_reg <= 1'b1;
    end else if (tck_ok && st == TPSP_UPD_DR && ir_reg == TPSP_IR_LOCK) begin
      lock_reg <= 1'b1;
    end
  end

  // Data out changes on the falling edge as the standard expects.
  always_ff @(posedge clk) begin
    if (srst) begin
      tdo_reg <= 1'b0;
      tdo_en_reg <= 1'b0;
    end else if (ce && test_reg && link.tck_fall) begin
      tdo_en_reg <= (st == TPSP_SH_IR) || (st == TPSP_SH_DR);
      if (st == TPSP_SH_IR) begin
        tdo_reg <= ir_sh_reg[0];
      end else if (ir_reg == TPSP_IR_PROBE) begin
        tdo_reg <= sel_sh_reg[0];
      end else begin
        tdo_reg <= byp_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pad drive
  // ---------------------------------------------------------------
  logic probing;
  assign probing = test_reg & !lock_reg & (ir_reg == TPSP_IR_PROBE);
  always_ff @(posedge clk) begin
    if (srst) begin
      {tck_pin_out, tdi_pin_out, tdo_pin_out} <= 3'b000;
      {tck_pin_oe, tdi_pin_oe, tdo_pin_oe} <= 3'b000;
      {probe_a_pin_out, probe_a_pin_oe, probe_b_pin_out, probe_b_pin_oe} <= 4'h0;
      user_in <= 3'b000;
      test_mode <= 1'b0;
      probe_locked <= 1'b0;
    end else if (ce) begin
      test_mode <= test_reg;
      probe_locked <= lock_reg;
      user_in <= {tck_s, tdi_s, s2_reg[2]};
      if (test_reg) begin
        {tck_pin_out, tdi_pin_out} <= 2'b00;
        {tck_pin_oe, tdi_pin_oe} <= 2'b00;
        tdo_pin_out <= tdo_reg;
        tdo_pin_oe <= tdo_en_reg;
      end else begin
        {tck_pin_out, tdi_pin_out, tdo_pin_out} <= user_out;
        {tck_pin_oe, tdi_pin_oe, tdo_pin_oe} <= user_oe;
      end
      if (probing) begin
        probe_a_pin_out <= nodes[sel_a_reg];
        probe_b_pin_out <= nodes[sel_b_reg];
        probe_a_pin_oe <= 1'b1;
        probe_b_pin_oe <= 1'b1;
      end else begin
        probe_a_pin_out <= user_pa_out;
        probe_a_pin_oe <= user_pa_oe;
        probe_b_pin_out <= user_pb_out;
        probe_b_pin_oe <= user_pb_oe;
      end
    end
  end

endmodule : tpsp_top
`default_nettype wire

// ===== sim/tpsp_tester.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Far-end tester; its clock stands still between frames.
// ----
module tpsp_tester (
  input wire logic clk,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  task automatic step(input logic m, input logic d);
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (4) @(posedge clk);
    tck <= 1'b0;
  endtask : step
  task automatic shift(input logic ir, input logic [7:0] v, input int n);
    step(1'b1, tdi);
    if (ir) step(1'b1, tdi);
    step(1'b0, tdi);
    step(1'b0, tdi);
    for (int i = 0; i < n; i++) step(i == n - 1, v[i]);
    step(1'b1, tdi);
    step(1'b0, tdi);
    // A released line must not keep its last bit, or a stale read would pass.
    tdi <= ~tdi;
    // The update lands in the pads a few clocks after the last edge.
    repeat (2) @(posedge clk);
  endtask : shift
endmodule : tpsp_tester
`default_nettype wire

// ===== sim/tpsp_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// Pin ownership checks
// ----
module tpsp_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic dedicated_mode,
  input wire logic tms_pin,
  input wire logic tck_pin_oe,
  input wire logic tdi_pin_oe,
  input wire logic tdo_pin_oe,
  input wire logic [2:0] user_oe,
  input wire logic user_pa_oe,
  input wire logic probe_a_pin_oe,
  input wire logic test_mode,
  input wire logic probe_locked
);
  logic [6:0] hi_cnt_reg;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // Counts held mode-select cycles so that a release that never comes is seen.
  always_ff @(posedge clk) begin
    hi_cnt_reg <= (tms_pin && test_mode && !dedicated_mode) ? hi_cnt_reg + 7'h01 : 7'h00;
  end
  sequence sel_fell_s;
    !dedicated_mode && $fell(tms_pin);
  endsequence
  sequence user_own_s;
    !test_mode && !$past(test_mode) && !$past(srst);
  endsequence
  enter_test_a: assert property (sel_fell_s |-> ##[1:5] test_mode)
    else $error("test mode late");
  hold_test_a: assert property ((test_mode && !tms_pin)[*6] |=> test_mode)
    else $error("test mode dropped early");
  early_rel_a: assert property ($fell(test_mode) |-> $past(tms_pin, 4))
    else $error("release too soon");
  late_rel_a: assert property (hi_cnt_reg < 7'h46)
    else $error("release never came");
  ded_own_a: assert property (dedicated_mode[*6] |-> test_mode)
    else $error("dedicated not owned");
  scan_own_a: assert property (test_mode && $past(test_mode) |-> !tck_pin_oe && !tdi_pin_oe)
    else $error("user drive in test");
  user_drive_a: assert property (user_own_s |-> {tck_pin_oe, tdi_pin_oe, tdo_pin_oe} == $past(user_oe))
    else $error("user enables lost");
  lock_keep_a: assert property ($past(probe_locked) |-> probe_locked)
    else $error("lock undone");
  lock_pass_a: assert property (probe_locked && !$past(srst) |-> probe_a_pin_oe == $past(user_pa_oe))
    else $error("probe pad not user");
endmodule : tpsp_chk
`default_nettype wire

// ===== sim/test_test_pin_share_probe.sv
`timescale 1ns/10ps
`default_nettype none
module test_test_pin_share_probe;
  import tpsp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic dedicated_mode = 1'b0;
  logic tms_pin, tk, td, tck_pin_out, tck_pin_oe, tdi_pin_out, tdi_pin_oe, tdo_pin_out, tdo_pin_oe;
  logic probe_a_pin_out, probe_a_pin_oe, probe_b_pin_out, probe_b_pin_oe, test_mode, probe_locked;
  logic [255:0] nodes = '0;
  logic [2:0] user_out = 3'h0, user_oe = 3'h0, user_in;
  logic user_pa_out = 1'b0, user_pa_oe = 1'b0, user_pb_out = 1'b0, user_pb_oe = 1'b0;
  wire logic tck_pin_in = tck_pin_oe ? tck_pin_out : tk;
  wire logic tdi_pin_in = tdi_pin_oe ? tdi_pin_out : td;
  wire logic tdo_pin_in = tdo_pin_out;
  wire logic [9:0] pads = {tck_pin_oe, tdi_pin_oe, tdo_pin_oe, tck_pin_out, tdi_pin_out,
    tdo_pin_out, probe_a_pin_oe, probe_a_pin_out, probe_b_pin_oe, probe_b_pin_out};
  int fails = 0, tests_run = 0;
  logic [31:0] r;
  logic [7:0] sel, prev;
  always #50 clk = ~clk;
  tpsp_tester t (.clk, .tck(tk), .tms(tms_pin), .tdi(td));
  tpsp_top dut (.clk, .srst, .ce, .dedicated_mode, .tms_pin, .tck_pin_in, .tck_pin_out,
    .tck_pin_oe, .tdi_pin_in, .tdi_pin_out, .tdi_pin_oe, .tdo_pin_in, .tdo_pin_out, .tdo_pin_oe,
    .probe_a_pin_out, .probe_a_pin_oe, .probe_b_pin_out, .probe_b_pin_oe, .nodes, .user_out,
    .user_oe, .user_in, .user_pa_out, .user_pa_oe, .user_pb_out, .user_pb_oe, .test_mode,
    .probe_locked);
  task automatic give_verdict();
    $display("counts: %0d compared, %0d failed", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_tm(input logic v);
    for (int k = 0; k < 100 && test_mode !== v; k++) @(negedge clk);
    if (test_mode !== v) begin
      fails++;
      $display("unexpected at %0t: test mode wait ran out", $time);
      give_verdict();
    end
    @(posedge clk);
  endtask : wait_tm
  task automatic user_io(input int n);
    repeat (n) begin
      r = $urandom;
      {user_oe, user_out, user_pa_oe, user_pa_out, user_pb_oe, user_pb_out} <= r[9:0];
      repeat (3) @(negedge clk);
      chk(pads, r[9:0]);
      repeat (2) @(negedge clk);
      chk({7'h00, user_in}, {7'h00, r[9] ? r[6] : tk, r[8] ? r[5] : td, r[4]});
      @(posedge clk);
    end
  endtask : user_io
  initial begin
    r = $urandom(32'h0000_073b);
    nodes = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    user_io(4);
    $display("done: user io");
    user_oe <= 3'h0;
    t.step(1'b0, 1'b0);
    wait_tm(1'b1);
    user_oe <= 3'h7;
    repeat (3) @(posedge clk);
    chk({8'h00, tck_pin_oe, tdi_pin_oe}, 10'h000);
    t.shift(1'b1, {4'h0, TPSP_IR_PROBE}, 4);
    prev = 8'h00;
    for (int i = 0; i < 4; i++) begin
      sel = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
      t.shift(1'b0, sel, 8);
      chk({8'h00, probe_a_pin_oe, probe_a_pin_out}, {8'h00, 1'b1, nodes[sel]});
      if (i > 0) chk({9'h000, probe_b_pin_out}, {9'h000, nodes[prev]});
      prev = sel;
    end
    $display("done: probe");
    t.step(1'b1, 1'b0);
    t.step(1'b0, 1'b0);
    t.step(1'b0, 1'b0);
    repeat (4) t.step(1'b1, 1'b0);
    repeat (8) @(posedge clk);
    chk({9'h000, test_mode}, 10'h001);
    t.step(1'b1, 1'b0);
    wait_tm(1'b0);
    repeat (3) @(posedge clk);
    chk({7'h00, tck_pin_oe, tdi_pin_oe, tdo_pin_oe}, 10'h007);
    user_oe <= 3'h0;
    $display("done: release");
    t.step(1'b0, 1'b0);
    wait_tm(1'b1);
    t.shift(1'b1, {4'h0, TPSP_IR_LOCK}, 4);
    t.shift(1'b0, 8'h00, 8);
    chk({9'h000, probe_locked}, 10'h001);
    repeat (5) t.step(1'b1, 1'b0);
    wait_tm(1'b0);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({9'h000, probe_locked}, 10'h001);
    user_io(3);
    $display("done: lock");
    dedicated_mode <= 1'b1;
    wait_tm(1'b1);
    repeat (8) @(posedge clk);
    chk({9'h000, test_mode}, 10'h001);
    srst <= 1'b1;
    $display("done: dedicated");
    give_verdict();
  end
endmodule : test_test_pin_share_probe
bind tpsp_top tpsp_chk chk (.clk, .srst, .dedicated_mode, .tms_pin, .tck_pin_oe, .tdi_pin_oe,
  .tdo_pin_oe, .user_oe, .user_pa_oe, .probe_a_pin_oe, .test_mode, .probe_locked);
`default_nettype wire
